// file: design/bcer_pkg.sv
package bcer_pkg;

	// register byte offsets on the configuration bus
	localparam logic [7:0]  OFS_CLK_STAT    = 8'h68;  // clock gating low half, cause flags byte 2
	localparam logic [7:0]  OFS_OPTION      = 8'h74;  // retry matching options
	localparam logic [7:0]  OFS_IRQ_STAT    = 8'h90;  // interrupt status, cleared by read
	localparam logic [7:0]  OFS_IRQ_MASK    = 8'h94;  // interrupt mask, same layout
	localparam logic [7:0]  OFS_SERR_CTRL   = 8'h98;  // error enable and per-event mask

	// field layout
	localparam int          CLK_OUTS        = 10;     // gated downstream clock outputs
	localparam int          CLK_PAIRS       = 4;      // outputs with a two-bit disable field
	localparam int          CLK_SINGLE_LSB  = 8;      // first single-bit disable field
	localparam int          CLK_FIELD_W     = 14;     // writable clock control bits 13:0
	localparam int          STAT_LSB        = 16;     // cause flags sit at bits 23:16
	localparam int          EVT_W           = 8;      // number of error causes
	localparam int          OPT_LSB         = 1;      // option bits 3:1 are writable
	localparam int          OPT_W           = 3;
	localparam int          CTRL_EN_BIT     = 0;      // error output enable
	localparam int          CTRL_MASK_LSB   = 8;      // per-event mask at bits 15:8

	// values after reset
	localparam logic [13:0] CLK_CTRL_RST    = 14'h0000;
	localparam logic [7:0]  FLAGS_RST       = 8'h00;
	localparam logic [2:0]  OPT_RST         = 3'h0;
	localparam logic [7:0]  MASK_RST        = 8'h00;
	localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

	// bus handshake states
	typedef enum logic {
		BUS_IDLE,
		BUS_ACK
	} bcer_bus_state_t;

endpackage : bcer_pkg

// file: design/bcer_flag_if.sv
`timescale 1ns/100ps
`default_nettype none

// sticky flag bundle between the register bank and a flag holder
interface bcer_flag_if;
	logic [bcer_pkg::EVT_W-1:0] set;  // hardware events
	logic [bcer_pkg::EVT_W-1:0] clr;  // software clear strobes
	logic [bcer_pkg::EVT_W-1:0] q;    // held flags

	modport owner (input set, input clr, output q);
	modport user  (output set, output clr, input q);
endinterface : bcer_flag_if

`default_nettype wire

// file: design/bcer_sticky.sv
`timescale 1ns/100ps
`default_nettype none

module bcer_sticky (
	input  wire logic        ref_clk,  // 20 MHz clock
	input  wire logic        rst_n,    // synchronous reset, active low
	bcer_flag_if.owner       flags     // set, clear and held flags
);

	// set is or-ed in after the clear so a coincident event survives
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			flags.q <= bcer_pkg::FLAGS_RST;
		else
			flags.q <= (flags.q & ~flags.clr) | flags.set;
	end

endmodule : bcer_sticky

`default_nettype wire

// file: design/bcer_clk_decode.sv
`timescale 1ns/100ps
`default_nettype none

module bcer_clk_decode (
	input  wire logic [bcer_pkg::CLK_FIELD_W-1:0] clk_ctrl,  // clock disable fields
	output logic      [bcer_pkg::CLK_OUTS-1:0]    clk_en     // per-output enable
);

	genvar i;

	// paired fields: a single stray 1 never stops a clock
	generate
		for (i = 0; i < bcer_pkg::CLK_PAIRS; i++)
		begin : g_pair
			assign clk_en[i] = ~(&clk_ctrl[2*i+1 -: 2]);
		end
		for (i = bcer_pkg::CLK_PAIRS; i < bcer_pkg::CLK_OUTS; i++)
		begin : g_single
			assign clk_en[i] = ~clk_ctrl[bcer_pkg::CLK_SINGLE_LSB + i - bcer_pkg::CLK_PAIRS];
		end
	endgenerate

endmodule : bcer_clk_decode

`default_nettype wire

// file: design/bcer_regs.sv
`timescale 1ns/100ps
`default_nettype none

module bcer_regs (
	input  wire logic        ref_clk,                    // 20 MHz clock
	input  wire logic        rst_n,                      // synchronous reset, active low
	input  wire logic [7:0]  avs_address,                // byte address
	input  wire logic        avs_read,                   // read request
	input  wire logic        avs_write,                  // write request
	input  wire logic [31:0] avs_writedata,              // write data
	input  wire logic [3:0]  avs_byteenable,             // byte lanes
	output logic      [31:0] avs_readdata,               // read data, valid with waitrequest low
	output logic             avs_waitrequest,            // high until the access is taken
	input  wire logic [7:0]  error_event,                // one-cycle cause pulses, bit n -> flag 16+n
	output logic      [9:0]  downstream_clock_en,        // 1 lets the clock run, 0 holds it low
	output logic             upstream_system_error_out,  // open-drain data, always low
	output logic             upstream_system_error_oe_n, // low while the error line is pulled
	output logic             primary_read_alias,         // primary read retries match loosely
	output logic             primary_write_alias,        // primary write retries match loosely
	output logic             secondary_read_alias,       // secondary read retries match loosely
	output logic             irq                         // level, unmasked status pending
);

	bcer_pkg::bcer_bus_state_t        bus_state_r;
	logic                             waitrequest_r;
	logic [31:0]                      readdata_r;
	logic [31:0]                      rd_nxt;
	logic [7:0]                       word_addr;
	logic                             acc;
	logic                             wr_acc;
	logic                             rd_acc;
	logic [bcer_pkg::CLK_FIELD_W-1:0] clk_ctrl_r;
	logic [bcer_pkg::CLK_OUTS-1:0]    clk_en_nxt;
	logic [bcer_pkg::CLK_OUTS-1:0]    clk_en_r;
	logic [bcer_pkg::OPT_W-1:0]       option_r;
	logic                             serr_en_r;
	logic [bcer_pkg::EVT_W-1:0]       serr_mask_r;
	logic [bcer_pkg::EVT_W-1:0]       irq_mask_r;
	logic [bcer_pkg::EVT_W-1:0]       irq_snap_r;
	logic [bcer_pkg::EVT_W-1:0]       ev_fire;
	logic                             serr_oe_n_r;
	logic                             irq_r;

	bcer_flag_if cause_if ();
	bcer_flag_if irq_if ();

	// low address bits are ignored, every register is one aligned word
	assign word_addr = {avs_address[7:2], 2'b00};
	assign acc       = (bus_state_r == bcer_pkg::BUS_ACK);
	assign wr_acc    = acc && avs_write;
	assign rd_acc    = acc && avs_read;

	// handshake: waitrequest drops for exactly one cycle, one cycle after the request
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			bus_state_r   <= bcer_pkg::BUS_IDLE;
			waitrequest_r <= 1'b1;
		end
		else
		begin
			case (bus_state_r)
				bcer_pkg::BUS_IDLE:
				begin
					if (avs_read || avs_write)
					begin
						bus_state_r   <= bcer_pkg::BUS_ACK;
						waitrequest_r <= 1'b0;
					end
				end
				bcer_pkg::BUS_ACK:
				begin
					bus_state_r   <= bcer_pkg::BUS_IDLE;
					waitrequest_r <= 1'b1;
				end
				default:
				begin
					bus_state_r   <= bcer_pkg::BUS_IDLE;
					waitrequest_r <= 1'b1;
				end
			endcase
		end
	end

	// read data mux; reserved and unmapped bits read zero
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		case (word_addr)
			bcer_pkg::OFS_CLK_STAT:
				rd_nxt = {8'h00, cause_if.q, 2'b00, clk_ctrl_r};
			bcer_pkg::OFS_OPTION:
				rd_nxt = {28'h000_0000, option_r, 1'b0};
			bcer_pkg::OFS_IRQ_STAT:
				rd_nxt = {24'h00_0000, irq_if.q};
			bcer_pkg::OFS_IRQ_MASK:
				rd_nxt = {24'h00_0000, irq_mask_r};
			bcer_pkg::OFS_SERR_CTRL:
				rd_nxt = {16'h0000, serr_mask_r, 7'h00, serr_en_r};
			default:
				rd_nxt = 32'h0000_0000;
		endcase
	end

	// data is captured as the request is seen and stands through the ack cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			readdata_r <= bcer_pkg::RDATA_RST;
			irq_snap_r <= bcer_pkg::FLAGS_RST;
		end
		else if (bus_state_r == bcer_pkg::BUS_IDLE && avs_read)
		begin
			readdata_r <= rd_nxt;
			irq_snap_r <= irq_if.q;  // only what software saw may be cleared
		end
	end

	// clock gating control; bits 15:14 have no storage
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			clk_ctrl_r <= bcer_pkg::CLK_CTRL_RST;
		else if (wr_acc && word_addr == bcer_pkg::OFS_CLK_STAT)
		begin
			if (avs_byteenable[0])
				clk_ctrl_r[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				clk_ctrl_r[13:8] <= avs_writedata[13:8];
		end
	end

	bcer_clk_decode u_clk_decode (
		.clk_ctrl (clk_ctrl_r),
		.clk_en   (clk_en_nxt)
	);

	// registered enables keep the pad gate free of decode glitches
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			clk_en_r <= {bcer_pkg::CLK_OUTS{1'b1}};
		else
			clk_en_r <= clk_en_nxt;
	end

	// retry matching options; bit 0 has no storage
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			option_r <= bcer_pkg::OPT_RST;
		else if (wr_acc && word_addr == bcer_pkg::OFS_OPTION && avs_byteenable[0])
			option_r <= avs_writedata[bcer_pkg::OPT_LSB +: bcer_pkg::OPT_W];
	end

	// error enable and per-event suppression mask
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			serr_en_r   <= 1'b0;
			serr_mask_r <= bcer_pkg::MASK_RST;
		end
		else if (wr_acc && word_addr == bcer_pkg::OFS_SERR_CTRL)
		begin
			if (avs_byteenable[0])
				serr_en_r <= avs_writedata[bcer_pkg::CTRL_EN_BIT];
			if (avs_byteenable[1])
				serr_mask_r <= avs_writedata[bcer_pkg::CTRL_MASK_LSB +: bcer_pkg::EVT_W];
		end
	end

	// interrupt mask, 1 lets a status bit reach irq
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			irq_mask_r <= bcer_pkg::MASK_RST;
		else if (wr_acc && word_addr == bcer_pkg::OFS_IRQ_MASK && avs_byteenable[0])
			irq_mask_r <= avs_writedata[7:0];
	end

	// an event counts only if it really drives the error line
	assign ev_fire = error_event & ~serr_mask_r & {bcer_pkg::EVT_W{serr_en_r}};

	// cause flags: set by a fired event, write-1-to-clear on byte lane 2
	assign cause_if.set = ev_fire;
	assign cause_if.clr = (wr_acc && word_addr == bcer_pkg::OFS_CLK_STAT && avs_byteenable[2])
		? avs_writedata[bcer_pkg::STAT_LSB +: bcer_pkg::EVT_W] : 8'h00;

	bcer_sticky u_cause_flags (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.flags   (cause_if)
	);

	// interrupt status: same events, cleared by reading it
	assign irq_if.set = ev_fire;
	assign irq_if.clr = (rd_acc && word_addr == bcer_pkg::OFS_IRQ_STAT) ? irq_snap_r : 8'h00;

	bcer_sticky u_irq_flags (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.flags   (irq_if)
	);

	// one-cycle pull of the open-drain error line per fired event
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			serr_oe_n_r <= 1'b1;
		else
			serr_oe_n_r <= ~(|ev_fire);
	end

	// level interrupt, falls once the read-clear lands
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			irq_r <= 1'b0;
		else
			irq_r <= |(irq_if.q & irq_mask_r);
	end

	// outputs straight from flops, except the error data tied low
	assign avs_readdata               = readdata_r;
	assign avs_waitrequest            = waitrequest_r;
	assign downstream_clock_en        = clk_en_r;
	assign upstream_system_error_out  = 1'b0;  // open drain only ever pulls low
	assign upstream_system_error_oe_n = serr_oe_n_r;
	assign primary_read_alias         = option_r[0];
	assign primary_write_alias        = option_r[1];
	assign secondary_read_alias       = option_r[2];
	assign irq                        = irq_r;

	// paired field stops the clock only with both bits set
	chk_pair_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		##1 (downstream_clock_en[3] == !(&$past(clk_ctrl_r[7:6]))))
		else $error("paired clock field decoded wrongly");

	// single field: 1 stops the clock
	chk_single_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		##1 (downstream_clock_en[9] == !$past(clk_ctrl_r[13])))
		else $error("single clock field decoded wrongly");

	// reserved clock bits read zero during the ack
	chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_acc && word_addr == bcer_pkg::OFS_CLK_STAT) |-> (avs_readdata[15:14] == 2'b00))
		else $error("reserved clock bits not zero");

	// each fired cause shows in the flags on the next cycle
	chk_cause_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(|ev_fire) |=> ((cause_if.q & $past(ev_fire)) == $past(ev_fire)))
		else $error("fired cause not recorded");

	// write-1 clears a flag when no event competes
	chk_w1c_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr_acc && word_addr == bcer_pkg::OFS_CLK_STAT && avs_byteenable[2]
			&& avs_writedata[16] && !ev_fire[0]) |=> !cause_if.q[0])
		else $error("write-1 did not clear flag");

	// coincident event beats the clear
	chk_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cause_if.clr[0] && ev_fire[0]) |=> cause_if.q[0])
		else $error("event lost to a clear");

	// option bit 0 always reads zero
	chk_opt_bit0: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_acc && word_addr == bcer_pkg::OFS_OPTION) |-> (avs_readdata[0] == 1'b0))
		else $error("option bit 0 not zero");

	// a write to the option word lands in the alias outputs
	chk_opt_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr_acc && word_addr == bcer_pkg::OFS_OPTION && avs_byteenable[0])
		|=> ({secondary_read_alias, primary_write_alias, primary_read_alias} == $past(avs_writedata[3:1])))
		else $error("option write not applied");

	// error line follows enabled unmasked events only
	chk_serr_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		##1 (upstream_system_error_oe_n == !($past(serr_en_r) && |($past(error_event) & ~$past(serr_mask_r)))))
		else $error("error line gating wrong");

	// waitrequest low for exactly one cycle per request
	chk_wait_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(bus_state_r == bcer_pkg::BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest pulse malformed");

	// paired field 0: one set bit alone keeps the clock running
	chk_pair0_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		##1 (downstream_clock_en[0] == !(&$past(clk_ctrl_r[1:0]))))
		else $error("paired clock field 0 decoded wrongly");

	// first single field, the lowest bit of the upper byte
	chk_single4_disable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		##1 (downstream_clock_en[4] == !$past(clk_ctrl_r[8])))
		else $error("single clock field 4 decoded wrongly");

	// all three options come out of reset cleared
	chk_opt_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> (!primary_read_alias && !primary_write_alias && !secondary_read_alias))
		else $error("options not cleared by reset");

	// options move only on a write to their word
	chk_opt_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!(wr_acc && word_addr == bcer_pkg::OFS_OPTION && avs_byteenable[0])
		|=> ($stable(primary_read_alias) && $stable(primary_write_alias) && $stable(secondary_read_alias)))
		else $error("option changed without a write");

	// held cause flag 7 falls only under its own clear
	chk_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cause_if.q[7] && !cause_if.clr[7]) |=> cause_if.q[7])
		else $error("flag fell without a clear");

	// with the error enable off the line never pulls
	chk_serr_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!serr_en_r |=> upstream_system_error_oe_n)
		else $error("error line pulled while disabled");

	// interrupt level follows unmasked status one cycle later
	chk_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(|(irq_if.q & irq_mask_r)) |=> irq)
		else $error("interrupt missing for pending status");

endmodule : bcer_regs

`default_nettype wire

// file: test/bcer_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// configuration master standing in for host software
module bcer_host_model (
	input  wire logic        ref_clk,         // bus clock
	output logic      [7:0]  avs_address,     // byte address
	output logic             avs_read,        // read request
	output logic             avs_write,       // write request
	output logic      [31:0] avs_writedata,   // write data
	output logic      [3:0]  avs_byteenable,  // byte lanes
	input  wire logic [31:0] avs_readdata,    // read data
	input  wire logic        avs_waitrequest  // low one cycle per access
);
	// idle values at time zero
	initial
	begin
		avs_address    = 8'hFF;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'hA5A5_A5A5;
		avs_byteenable = 4'h0;
	end

	// one access; the slave's latency is never assumed, the bench timeout cuts a hang
	task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address    <= a;
		avs_read       <= ~wr;
		avs_write      <= wr;
		avs_writedata  <= d;
		avs_byteenable <= be;
		do
			@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		// released lines are scrambled so stale values never look valid
		avs_read       <= 1'b0;
		avs_write      <= 1'b0;
		avs_address    <= ~a;
		avs_writedata  <= ~d;
		avs_byteenable <= ~be;
	endtask : access
endmodule : bcer_host_model

`default_nettype wire

// file: test/bcer_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module bcer_regs_tb;
	logic        ref_clk;
	logic        rst_n;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  error_event;
	logic [9:0]  downstream_clock_en;
	logic        serr_out;
	logic        serr_oe_n;
	logic [2:0]  alias_q;
	logic        irq;
	logic [31:0] q;
	logic [15:0] cv [2];
	int          n_mismatch;
	int          cmp_count;
	int          cycles;

	bcer_host_model host (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

	bcer_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .error_event(error_event),
		.downstream_clock_en(downstream_clock_en), .upstream_system_error_out(serr_out),
		.upstream_system_error_oe_n(serr_oe_n), .primary_read_alias(alias_q[0]),
		.primary_write_alias(alias_q[1]), .secondary_read_alias(alias_q[2]), .irq(irq));

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			$display("unexpected at %0t: run did not finish", $time);
			wrap_up();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] unused;
		host.access(1'b1, a, d, be, unused);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		host.access(1'b0, a, 32'h0000_0000, 4'hF, d);
	endtask : rd

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: register %h, wanted %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic [9:0] got, input logic [9:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: output %h, wanted %h", $time, got, exp);
		end
	endtask : chk_pin

	// one-cycle event pulse, returns mid-cycle after the event was sampled
	task automatic pulse(input logic [7:0] ev);
		@(posedge ref_clk);
		error_event <= ev;
		@(posedge ref_clk);
		error_event <= 8'h00;
		@(negedge ref_clk);
	endtask : pulse

	// pairs stop only when both bits are set, singles stop on a one
	function automatic logic [9:0] exp_en(input logic [15:0] c);
		logic [9:0] e;
		for (int i = 0; i < 4; i++)
			e[i] = ~(c[2*i] & c[2*i+1]);
		for (int i = 4; i < 10; i++)
			e[i] = ~c[i+4];
		return e;
	endfunction : exp_en

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	initial
	begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		error_event = 8'h00;
		cv = '{16'hEA39, 16'hFFFF};
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(bcer_pkg::OFS_CLK_STAT, q);
		chk_reg(q, 32'h0000_0000);
		rd(bcer_pkg::OFS_OPTION, q);
		chk_reg(q, 32'h0000_0000);
		chk_pin(downstream_clock_en, 10'h3FF);
		chk_pin({7'h00, alias_q}, 10'h000);
		$display("test reset done");
		// all four pair codes, mixed singles, reserved bits written as ones
		for (int i = 0; i < 2; i++)
		begin
			wr(bcer_pkg::OFS_CLK_STAT, {16'h0000, cv[i]}, 4'h3);
			rd(bcer_pkg::OFS_CLK_STAT, q);
			chk_reg(q, {18'h00000, cv[i][13:0]});
			chk_pin(downstream_clock_en, exp_en(cv[i]));
		end
		wr(bcer_pkg::OFS_CLK_STAT, 32'h0000_0000, 4'h3);
		// enables are registered behind the control word, let them settle
		repeat (2) @(negedge ref_clk);
		chk_pin(downstream_clock_en, 10'h3FF);
		$display("test clock gating done");
		for (int i = 0; i < 4; i++)
		begin
			wr(bcer_pkg::OFS_OPTION, 32'hFFFF_FFF0 | (32'h1 << i), 4'hF);
			rd(bcer_pkg::OFS_OPTION, q);
			chk_reg(q, (32'h1 << i) & 32'h0000_000E);
			chk_pin({7'h00, alias_q}, 10'((32'h1 << i) >> 1));
		end
		$display("test options done");
		wr(bcer_pkg::OFS_SERR_CTRL, 32'h0000_0001, 4'hF);
		wr(bcer_pkg::OFS_IRQ_MASK, 32'h0000_00FF, 4'hF);
		for (int i = 0; i < 8; i++)
		begin
			pulse(8'h01 << i);
			chk_pin({8'h00, serr_out, serr_oe_n}, 10'h000);
			@(negedge ref_clk);
			chk_pin({9'h000, irq}, 10'h001);
			rd(bcer_pkg::OFS_CLK_STAT, q);
			chk_reg(q, 32'h1 << (16 + i));
			rd(bcer_pkg::OFS_IRQ_STAT, q);
			chk_reg(q, 32'h1 << i);
			repeat (2) @(negedge ref_clk);
			chk_pin({9'h000, irq}, 10'h000);
			// zeros leave the flag alone, only its own one clears it
			wr(bcer_pkg::OFS_CLK_STAT, 32'h00FF_0000 ^ (32'h1 << (16 + i)), 4'h4);
			rd(bcer_pkg::OFS_CLK_STAT, q);
			chk_reg(q, 32'h1 << (16 + i));
			wr(bcer_pkg::OFS_CLK_STAT, 32'h1 << (16 + i), 4'h4);
			rd(bcer_pkg::OFS_CLK_STAT, q);
			chk_reg(q, 32'h0000_0000);
		end
		$display("test cause flags done");
		wr(bcer_pkg::OFS_SERR_CTRL, 32'h0000_0801, 4'hF);
		pulse(8'h08);
		chk_pin({9'h000, serr_oe_n}, 10'h001);
		wr(bcer_pkg::OFS_SERR_CTRL, 32'h0000_0000, 4'hF);
		pulse(8'h01);
		chk_pin({9'h000, serr_oe_n}, 10'h001);
		rd(bcer_pkg::OFS_CLK_STAT, q);
		chk_reg(q, 32'h0000_0000);
		wr(bcer_pkg::OFS_SERR_CTRL, 32'h0000_0001, 4'hF);
		wr(bcer_pkg::OFS_IRQ_MASK, 32'h0000_0000, 4'hF);
		pulse(8'h02);
		repeat (2) @(negedge ref_clk);
		chk_pin({9'h000, irq}, 10'h000);
		rd(bcer_pkg::OFS_IRQ_STAT, q);
		chk_reg(q, 32'h0000_0002);
		$display("test suppression done");
		// event held high across the edge where its clear lands
		@(posedge ref_clk);
		error_event <= 8'h01;
		wr(bcer_pkg::OFS_CLK_STAT, 32'h0003_0000, 4'h4);
		error_event <= 8'h00;
		rd(bcer_pkg::OFS_CLK_STAT, q);
		chk_reg(q, 32'h0001_0000);
		wr(8'h40, 32'hFFFF_FFFF, 4'hF);
		rd(8'h40, q);
		chk_reg(q, 32'h0000_0000);
		$display("test collision and unmapped done");
		wrap_up();
	end
endmodule : bcer_regs_tb

`default_nettype wire
